// [hw/pld_init_consts.svh]
// Constants for the register init and security block
`ifndef PLD_INIT_CONSTS_SVH
`define PLD_INIT_CONSTS_SVH
`define PLD_SIG_BITS 64
`define PLD_NUM_REGS 10
`define PLD_CFG_BITS 32
`define PLD_PWRUP_NS 1000
`define PLD_CLK_NS 10
`define PLD_PWRUP_CYCLES (`PLD_PWRUP_NS / `PLD_CLK_NS)
`define PLD_ERASE_CYCLES 4
`endif

// [hw/pld_init_pkg.sv]
// Types for the register init and security block
package pld_init_pkg;
	typedef enum logic [3:0] {
		ST_PWRUP = 4'h1,
		ST_RUN = 4'h2,
		ST_ERASE = 4'h4,
		ST_WRITE = 4'h8
	} pld_state_e;
endpackage

// [hw/pld_register_init_and_security.sv]
// Power-up reset, preload, signature and security logic of a small PLD
//
// Behaviour
// (RULE1) A 64-bit user-defined signature store is held and may be reprogrammed.
// (RULE2) The signature reads back at all times regardless of the security cell.
// (RULE3) Once the security cell is set, configuration readback returns nothing.
// (RULE4) The security cell clears only during a full reprogramming; the code also clears it whenever i_reset_n is low.
// (RULE5) Each programming cycle erases the configuration by itself.
// (RULE6) Preload forces each registered output high or low synchronously.
// (RULE7) At power-up every output register is reset low within 1 us.
// (RULE8) Enabled registered pins show the register through the programmed polarity.
// (RULE9) The system keeps the clock steady during power-up.
// (RULE10) The system does not clock until setup times and pulse widths are met.
// (RULE11) Undriven inputs and tri-stated pins read as logic 1.
// (RULE12) The preload value replaces next-state logic at the edge, then sequencing resumes.
`timescale 1ns/1ps
`include "pld_init_consts.svh"
module pld_register_init_and_security #(
	parameter int NREG = `PLD_NUM_REGS,
	parameter int CFGW = `PLD_CFG_BITS
) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [NREG-1:0] i_next_state,
	input wire logic [NREG-1:0] i_pin_in,
	input wire logic [NREG-1:0] i_pin_drive,
	input wire logic i_preload,
	input wire logic [NREG-1:0] i_preload_val,
	input wire logic [NREG-1:0] i_out_enable,
	input wire logic [NREG-1:0] i_polarity_high,
	input wire logic i_prog_start,
	input wire logic [CFGW-1:0] i_prog_cfg,
	input wire logic [`PLD_SIG_BITS-1:0] i_prog_sig,
	input wire logic i_prog_secure,
	output logic [NREG-1:0] o_pin_out,
	output logic [NREG-1:0] o_pin_oe,
	output logic [NREG-1:0] o_pin_level,
	output logic [`PLD_SIG_BITS-1:0] o_signature,
	output logic [CFGW-1:0] o_cfg_readback,
	output logic o_cfg_read_ok,
	output logic o_secure,
	output logic o_busy,
	output logic o_pwrup_done
);
	import pld_init_pkg::*;
	localparam int PWR_CYC = (`PLD_PWRUP_CYCLES < 1) ? 1 : `PLD_PWRUP_CYCLES;
	// Sequencer: power-up, run and the two programming phases
	pld_state_e state_reg, state_next;
	logic [7:0] cnt_reg, cnt_next;
	logic busy_reg, busy_next;
	logic done_reg, done_next;
	// Macrocell registers
	logic [NREG-1:0] q_reg, q_next;
	// Nonvolatile image: configuration, signature and security cell
	logic [CFGW-1:0] cfg_reg, cfg_next;
	logic [`PLD_SIG_BITS-1:0] sig_reg, sig_next;
	logic sec_reg, sec_next;
	// Pin-side registers
	logic [NREG-1:0] pin_out_reg, pin_out_next;
	logic [NREG-1:0] oe_reg, oe_next;
	logic [NREG-1:0] lvl_reg, lvl_next;
	// Readback port
	logic [CFGW-1:0] rb_reg, rb_next;
	logic rb_ok_reg, rb_ok_next;
	logic [NREG-1:0] pin_seen;
	logic [NREG-1:0] pol_view;
	logic run_now;
	logic prog_go;

	assign run_now = (state_reg == ST_RUN);
	// Programming wins over preload when both arrive together
	assign prog_go = run_now && i_prog_start;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			ST_PWRUP: begin
				if (cnt_reg >= 8'(PWR_CYC - 1)) begin
					state_next = ST_RUN;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			ST_RUN: begin
				if (prog_go) begin
					state_next = ST_ERASE;
					cnt_next = 8'h00;
				end
			end
			ST_ERASE: begin
				if (cnt_reg >= 8'(`PLD_ERASE_CYCLES - 1)) begin
					state_next = ST_WRITE;
				end else begin
					cnt_next = cnt_reg + 8'h01;
				end
			end
			ST_WRITE: begin
				state_next = ST_RUN;
			end
			default: begin
				state_next = ST_PWRUP;
				cnt_next = 8'h00;
			end
		endcase
		// Status flags are registered copies of the coming state
		busy_next = (state_next == ST_ERASE) || (state_next == ST_WRITE);
		done_next = (state_next != ST_PWRUP);
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			state_reg <= ST_PWRUP;
			cnt_reg <= 8'h00;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			busy_reg <= busy_next;
			done_reg <= done_next;
		end
	end

	always_comb begin
		q_next = q_reg;
		case (state_reg)
			ST_PWRUP: begin
				// (RULE7) registers low during power-up
				q_next = '0;
			end
			ST_RUN: begin
				if (prog_go) begin
					q_next = q_reg;
				// (RULE6) synchronous preload
				end else if (i_preload) begin
					// (RULE12) forced value replaces next state
					q_next = i_preload_val;
				end else begin
					q_next = i_next_state;
				end
			end
			ST_WRITE: begin
				q_next = '0;
			end
			default: begin
				q_next = q_reg;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			q_reg <= '0;
		end else begin
			q_reg <= q_next;
		end
	end

	always_comb begin
		cfg_next = cfg_reg;
		sig_next = sig_reg;
		sec_next = sec_reg;
		case (state_reg)
			ST_ERASE: begin
				// (RULE5) automatic erase
				cfg_next = '0;
				sig_next = '0;
				// (RULE4) clear security here and at reset
				sec_next = 1'b0;
			end
			ST_WRITE: begin
				cfg_next = i_prog_cfg;
				// (RULE1) store user signature
				sig_next = i_prog_sig;
				sec_next = i_prog_secure;
			end
			default: begin
				cfg_next = cfg_reg;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			cfg_reg <= '0;
			sig_reg <= '0;
			sec_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			sig_reg <= sig_next;
			sec_reg <= sec_next;
		end
	end

	// Per-pin pull-up and output polarity
	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_pin
			// (RULE11) pull-up on pin
			assign pin_seen[g] = i_pin_drive[g] ? i_pin_in[g] : 1'b1;
			// (RULE8) pins follow polarity
			assign pol_view[g] = i_polarity_high[g] ? q_next[g] : ~q_next[g];
		end
	endgenerate

	always_comb begin
		pin_out_next = pol_view;
		oe_next = i_out_enable;
		lvl_next = pin_seen;
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			pin_out_reg <= '0;
			oe_reg <= '0;
			lvl_reg <= '1;
		end else begin
			pin_out_reg <= pin_out_next;
			oe_reg <= oe_next;
			lvl_reg <= lvl_next;
		end
	end

	always_comb begin
		// (RULE3) block readback when secured
		rb_ok_next = !sec_reg && run_now;
		rb_next = '0;
		if (rb_ok_next) begin
			rb_next = cfg_reg;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			rb_reg <= '0;
			rb_ok_reg <= 1'b0;
		end else begin
			rb_reg <= rb_next;
			rb_ok_reg <= rb_ok_next;
		end
	end

	assign o_pin_out = pin_out_reg;
	assign o_pin_oe = oe_reg;
	assign o_pin_level = lvl_reg;
	// (RULE2) signature always readable
	assign o_signature = sig_reg;
	assign o_cfg_readback = rb_reg;
	assign o_cfg_read_ok = rb_ok_reg;
	assign o_secure = sec_reg;
	assign o_busy = busy_reg;
	assign o_pwrup_done = done_reg;
endmodule

// [testbench/pld_register_init_and_security_monitor.sv]
// Checker for the init and security block
`timescale 1ns/1ps
module pld_init_monitor #(parameter int NREG = 10, parameter int CFGW = 32) (
	input wire logic i_sys_clk,
	input wire logic i_reset_n,
	input wire logic [NREG-1:0] i_pin_in,
	input wire logic [NREG-1:0] i_pin_drive,
	input wire logic i_preload,
	input wire logic [NREG-1:0] i_preload_val,
	input wire logic [NREG-1:0] i_out_enable,
	input wire logic [NREG-1:0] i_polarity_high,
	input wire logic i_prog_start,
	input wire logic [NREG-1:0] o_pin_out,
	input wire logic [NREG-1:0] o_pin_oe,
	input wire logic [NREG-1:0] o_pin_level,
	input wire logic [CFGW-1:0] o_cfg_readback,
	input wire logic o_cfg_read_ok,
	input wire logic o_secure,
	input wire logic o_busy,
	input wire logic o_pwrup_done
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);
	wire run = o_pwrup_done && !o_busy;
	sequence s_prog;
		o_busy [*5] ##1 !o_busy;
	endsequence
	a_pwrup_time: assert property ($rose(i_reset_n) |->
		##99 !o_pwrup_done ##1 o_pwrup_done)
		else $error("pwrup length");
	a_pwrup_low: assert property (!o_pwrup_done && $past(i_reset_n) |->
		o_pin_out == ~i_polarity_high)
		else $error("pwrup level");
	a_preload_force: assert property (run && i_preload && !i_prog_start |=>
		o_pin_out == ~($past(i_preload_val) ^ $past(i_polarity_high)))
		else $error("preload");
	a_oe_delay: assert property ($past(i_reset_n) |-> o_pin_oe == $past(i_out_enable))
		else $error("oe");
	a_pull_up: assert property ($past(i_reset_n) |->
		o_pin_level == ($past(i_pin_in) | ~$past(i_pin_drive)))
		else $error("pull-up");
	a_prog_walk: assert property (run && i_prog_start |=> s_prog)
		else $error("prog walk");
	a_erase_clear: assert property ($rose(o_busy) |=> !o_secure)
		else $error("erase");
	a_secure_hide: assert property (o_secure |-> o_cfg_readback == 0 && !o_cfg_read_ok)
		else $error("secure");
endmodule
bind pld_register_init_and_security pld_init_monitor #(.NREG(NREG), .CFGW(CFGW)) mon (.*);

// [testbench/pld_programmer.sv]
// Programmer model driving the programming port
`timescale 1ns/1ps
module pld_programmer (
	input wire logic i_sys_clk,
	output logic o_start,
	output logic [31:0] o_cfg,
	output logic [63:0] o_sig,
	output logic o_secure
);
	initial begin
		{o_start, o_cfg, o_sig, o_secure} = 98'h0;
	end
	task automatic load(input logic [31:0] c, input logic [63:0] s, input logic sec);
		@(posedge i_sys_clk);
		#1;
		{o_cfg, o_sig, o_secure, o_start} = {c, s, sec, 1'h1};
		@(posedge i_sys_clk);
		#1;
		o_start = 1'h0;
		repeat (8) @(posedge i_sys_clk);
		#1;
	endtask
endmodule

// [testbench/pld_register_init_and_security_tb_top.sv]
// Testbench for the init and security block
`timescale 1ns/1ps
`include "pld_init_consts.svh"
module pld_register_init_and_security_tb_top;
	logic i_sys_clk = 1'h0, i_reset_n = 1'h0, i_preload = 1'h0, i_prog_start, i_prog_secure;
	logic [9:0] i_next_state = 10'h0, i_pin_in = 10'h0, i_pin_drive = 10'h0;
	logic [9:0] i_preload_val = 10'h0, i_out_enable = 10'h0, i_polarity_high = 10'h30F;
	logic [9:0] o_pin_out, o_pin_oe, o_pin_level;
	logic [63:0] o_signature, i_prog_sig;
	logic [31:0] o_cfg_readback, i_prog_cfg;
	logic o_cfg_read_ok, o_secure, o_busy, o_pwrup_done;
	int fails = 0, n_tests = 0, k;
	always #5 i_sys_clk = ~i_sys_clk;
	pld_register_init_and_security #(.NREG(10), .CFGW(32)) uut (.*);
	pld_programmer prog (.i_sys_clk(i_sys_clk), .o_start(i_prog_start), .o_cfg(i_prog_cfg),
		.o_sig(i_prog_sig), .o_secure(i_prog_secure));
	task step();
		@(posedge i_sys_clk);
		#1;
	endtask
	task chk(input string n, input logic [63:0] s, input logic [63:0] e);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task t_pwrup();
		repeat (2) step();
		// system side stays quiet: no preload or programming until power-up ends
		i_next_state = 10'h3FF;
		i_reset_n = 1'h1;
		step();
		chk("pwrup", o_pin_out, 10'h0F0);
		k = 1;
		while (o_pwrup_done !== 1'h1 && k < 200) begin
			step();
			k++;
		end
		chk("pwrup len", k, `PLD_PWRUP_CYCLES);
		if (k == 200)
			test_done();
		chk("pwrup hold", o_pin_out, 10'h0F0);
		$display("pwrup done");
	endtask
	task t_pre();
		{i_preload, i_preload_val, i_pin_in, i_pin_drive} = {1'h1, 10'h2A5, 10'h0F0, 10'h3C3};
		i_out_enable = 10'h155;
		step();
		chk("preload", o_pin_out, 10'h255);
		chk("level", o_pin_level, 10'h0FC);
		chk("oe", o_pin_oe, 10'h155);
		i_preload = 1'h0;
		i_next_state = 10'h15A;
		step();
		chk("resume", o_pin_out, 10'h1AA);
		$display("preload done");
	endtask
	task t_prog();
		prog.load(32'h1234ABCD, 64'hFEED0000C0DE0001, 1'h1);
		chk("sig", o_signature, 64'hFEED0000C0DE0001);
		chk("idle", {o_busy, o_pwrup_done}, 2'h1);
		chk("hidden", {o_secure, o_cfg_read_ok, o_cfg_readback}, 34'h200000000);
		prog.load(32'h0BADF00D, 64'h0123456789ABCDEF, 1'h0);
		chk("reload", {o_secure, o_cfg_read_ok, o_cfg_readback}, 34'h10BADF00D);
		chk("sig2", o_signature, 64'h0123456789ABCDEF);
		$display("prog done");
	endtask
	initial begin
		t_pwrup();
		t_pre();
		t_prog();
		test_done();
	end
endmodule
